// [sap_cfg.svh]
/*
 * Register offsets, field positions, reset values and masks of the serial audio port.
 * Assumes byte addresses on an APB bus with 32-bit data, one register per word.
 */
`ifndef SAP_CFG_SVH
`define SAP_CFG_SVH

`define SAP_OFF_STAT 8'h08
`define SAP_OFF_DATA 8'h0C
`define SAP_OFF_POLY 8'h10
`define SAP_OFF_RSUM 8'h14
`define SAP_OFF_TSUM 8'h18
`define SAP_OFF_ACTL 8'h1C
`define SAP_OFF_APSC 8'h20
`define SAP_OFF_PCFG 8'h24

`define SAP_STAT_RST 16'h0002
`define SAP_POLY_RST 16'h0007
`define SAP_ACTL_RST 12'h000
`define SAP_APSC_RST 10'h002
`define SAP_PCFG_RST 7'h00
`define SAP_ACTL_MASK 16'h0FBF
`define SAP_APSC_MASK 16'h03FF
`define SAP_PCFG_MASK 16'h007F
`define SAP_MASK_8 16'h00FF
`define SAP_MASK_16 16'hFFFF

`define SAP_STAT_MISMATCH 4
`define SAP_APSC_MASTER_CLOCK_OUT_ENABLE 9
`define SAP_APSC_ODD 8
`define SAP_DIV_MIN 9'h002

`endif

// [sap_pkg.sv]
/*
 * Types of the serial audio port register block.
 * Assumes the shifter and the APB master run on the same clock.
 */
package sap_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} sap_apb_req_t;

	typedef enum logic [1:0] {
		SAP_OP_SLAVE_TX = 2'h0,
		SAP_OP_SLAVE_RX = 2'h1,
		SAP_OP_MASTER_TX = 2'h2,
		SAP_OP_MASTER_RX = 2'h3
	} sap_op_mode_t;

	typedef enum logic [1:0] {
		SAP_STD_I2S = 2'h0,
		SAP_STD_LEFT = 2'h1,
		SAP_STD_RIGHT = 2'h2,
		SAP_STD_PCM = 2'h3
	} sap_std_t;

	typedef struct packed {
		logic audio_mode_select;
		logic audio_enable;
		sap_op_mode_t audio_op_mode;
		logic pcm_sync_length;
		sap_std_t audio_standard;
		logic idle_clock_level;
		logic [1:0] sample_length;
		logic slot_length;
	} sap_audio_cfg_t;

	typedef struct packed {
		logic port_enable;
		logic master_mode;
		logic lsb_first;
		logic soft_select_level;
		logic soft_select_enable;
		logic frame16;
		logic checksum_enable;
	} sap_port_cfg_t;

	typedef struct packed {
		logic rx_bit_stb;
		logic rx_bit;
		logic tx_bit_stb;
		logic tx_bit;
		logic rx_frame_stb;
		logic rx_sum_stb;
		logic [15:0] rx_word;
		logic tx_take;
		logic underrun_evt;
		logic channel_side;
		logic transfer_active;
	} sap_link_evt_t;

endpackage : sap_pkg

// [sap_regs.sv]
/*
 * Status, data, checksum and audio configuration registers of the serial audio port.
 * Assumes an APB master on sys_clk and a shifter on sys_clk that reports bits and frames.
 */
`timescale 1ns/100ps
`include "sap_cfg.svh"

// Function
// - Overrun flag bit 6 stays set until a data read then a status read.
// - Master mode: select low (pin or soft level) sets config fault bit 5.
// - Config fault clears on status access followed by control write; not in audio mode.
// - Checksum mismatch bit 4 set on compare failure, cleared by writing 0.
// - Underrun bit 3 set by hardware in audio mode, cleared by status read.
// - Channel side bit 2: 0 left, 1 right; meaningless in PCM.
// - Bit 1 shows transmit buffer empty, bit 0 shows receive data waiting.
// - Data writes fill transmit buffer; data reads return receive buffer.
// - 8-bit frames force data bits 15:8 to zero; 16-bit frames use all.
// - Programmable 16-bit polynomial resets to 0x0007 and drives checksum.
// - Receive checksum over received bits, 8 or 16 bit by frame width.
// - Transmit checksum over transmitted bits, same width rule.
// - Checksums step on every shifted bit while checksum enable is set outside audio mode; mid-transfer reads show partial values.
// - Both checksums clear when checksum enable sets or peripheral reset asserts.
// - Bit order changes transmit checksum since bits arrive in wire order.
// - Bit 11 selects audio mode, bit 10 enables audio; change while disabled.
// - Audio operation field 9:8: slave tx, slave rx, master tx, master rx.
// - Bit 7 picks short or long frame sync in PCM only.
// - Audio standard field 5:4: I2S, left, right justified, PCM.
// - Idle bit clock level follows bit 3.
// - Sample length 2:1 is 16, 24, 32; bit 0 slot 16 or 32.
// - Clock divides by twice factor plus odd bit; bit 9 enables master clock.
// - Status register at offset 0x08, resets to 0x0002.
module sap_regs
	import sap_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire sap_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sap_link_evt_t link_evt,
	input wire logic slave_select,
	input wire logic peripheral_reset_bit,
	output logic [15:0] tx_buffer,
	output logic tx_buffer_empty,
	output logic [15:0] tx_checksum,
	output sap_port_cfg_t port_cfg,
	output sap_audio_cfg_t audio_cfg,
	output logic audio_bit_clock,
	output logic audio_master_clock
);

	if (DATA_W != 16) begin : g_bad_width
		$error("sap_regs serves a 16-bit data field only");
	end

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [15:0] res;
		res = old;
		if (st[0]) begin
			res[7:0] = wd[7:0];
		end
		if (st[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction : merge16

	function automatic logic [15:0] sum_step(input logic [15:0] sum, input logic [15:0] poly,
		input logic din, input logic wide);
		logic top;
		logic [15:0] nxt;
		top = wide ? sum[15] : sum[7];
		nxt = {sum[14:0], 1'b0};
		if (top ^ din) begin
			nxt = nxt ^ poly;
		end
		if (!wide) begin
			nxt[15:8] = 8'h00;
		end
		return nxt;
	endfunction : sum_step

	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic ss_meta_q, ss_sync_q;
	sap_port_cfg_t pcfg_q;
	logic [11:0] actl_q;
	logic [9:0] apsc_q;
	logic [15:0] poly_q, tx_buf_q, rx_buf_q, rx_sum_q, tx_sum_q;
	logic rx_ovr_q, ovr_arm_q, cfg_fault_q, cfg_arm_q, mismatch_q, tx_ur_q;
	logic ch_side_q, tx_empty_q, rx_pend_q, transfer_active_q;
	sap_audio_cfg_t audio_cfg_q;
	logic [8:0] div_cnt_q;
	logic bck_q, mck_q;

	logic setup, rd_stb, wr_stb, mapped;
	logic hit_stat, hit_data, hit_poly, hit_rsum, hit_tsum, hit_actl, hit_apsc, hit_pcfg;
	logic data_rd, data_wr, stat_rd, stat_wr, ctl_wr, sum_clr, audio_sel;
	logic rx_acc, ovr_evt, fault_evt, sel_low, mismatch_evt;
	logic [15:0] fmask, stat_word, rdata16;
	logic [8:0] divisor;
	logic running, tick;
	sap_port_cfg_t pcfg_new;

	// Address decode, reads act in the setup cycle, writes at the completing edge
	assign setup = apb_req.psel & ~apb_req.penable;
	assign rd_stb = setup & ~apb_req.pwrite;
	assign wr_stb = apb_req.psel & apb_req.penable & pready_q & apb_req.pwrite;
	assign hit_stat = apb_req.paddr == `SAP_OFF_STAT;
	assign hit_data = apb_req.paddr == `SAP_OFF_DATA;
	assign hit_poly = apb_req.paddr == `SAP_OFF_POLY;
	assign hit_rsum = apb_req.paddr == `SAP_OFF_RSUM;
	assign hit_tsum = apb_req.paddr == `SAP_OFF_TSUM;
	assign hit_actl = apb_req.paddr == `SAP_OFF_ACTL;
	assign hit_apsc = apb_req.paddr == `SAP_OFF_APSC;
	assign hit_pcfg = apb_req.paddr == `SAP_OFF_PCFG;
	assign mapped = hit_stat | hit_data | hit_poly | hit_rsum | hit_tsum | hit_actl
		| hit_apsc | hit_pcfg;
	assign data_rd = rd_stb & hit_data;
	assign data_wr = wr_stb & hit_data;
	assign stat_rd = rd_stb & hit_stat;
	assign stat_wr = wr_stb & hit_stat;
	assign ctl_wr = wr_stb & hit_pcfg;
	assign audio_sel = actl_q[11];
	assign fmask = pcfg_q.frame16 ? `SAP_MASK_16 : `SAP_MASK_8;
	assign pcfg_new = sap_port_cfg_t'(merge16({9'h000, pcfg_q}, apb_req.pwdata,
		apb_req.pstrb) & `SAP_PCFG_MASK);
	assign sum_clr = peripheral_reset_bit | (ctl_wr & pcfg_new.checksum_enable
		& ~pcfg_q.checksum_enable);

	assign stat_word = {8'h00, transfer_active_q, rx_ovr_q, cfg_fault_q, mismatch_q, tx_ur_q,
		ch_side_q, tx_empty_q, rx_pend_q};

	always_comb begin
		rdata16 = 16'h0000;
		case (1'b1)
			hit_stat: rdata16 = stat_word;
			hit_data: rdata16 = rx_buf_q & fmask;
			hit_poly: rdata16 = poly_q;
			hit_rsum: rdata16 = rx_sum_q;
			hit_tsum: rdata16 = tx_sum_q;
			hit_actl: rdata16 = {4'h0, actl_q};
			hit_apsc: rdata16 = {6'h00, apsc_q};
			hit_pcfg: rdata16 = {9'h000, pcfg_q};
			default: rdata16 = 16'h0000;
		endcase
	end

	// APB answer: one wait-free access phase
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			if (rd_stb) begin
				prdata_q <= {16'h0000, rdata16};
			end
		end
	end

	// Select pin synchroniser
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ss_meta_q <= 1'b1;
			ss_sync_q <= 1'b1;
		end else begin
			ss_meta_q <= slave_select;
			ss_sync_q <= ss_meta_q;
		end
	end

	// Configuration registers with byte-lane writes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pcfg_q <= `SAP_PCFG_RST;
			actl_q <= `SAP_ACTL_RST;
			apsc_q <= `SAP_APSC_RST;
			poly_q <= `SAP_POLY_RST;
		end else if (wr_stb) begin
			if (hit_pcfg) begin
				pcfg_q <= pcfg_new;
			end
			if (hit_actl) begin
				actl_q <= 12'(merge16({4'h0, actl_q}, apb_req.pwdata, apb_req.pstrb)
					& `SAP_ACTL_MASK);
			end
			if (hit_apsc) begin
				apsc_q <= 10'(merge16({6'h00, apsc_q}, apb_req.pwdata, apb_req.pstrb)
					& `SAP_APSC_MASK);
			end
			if (hit_poly) begin
				poly_q <= merge16(poly_q, apb_req.pwdata, apb_req.pstrb);
			end
		end
	end

	// Data buffers
	assign rx_acc = link_evt.rx_frame_stb & (~rx_pend_q | data_rd);
	assign ovr_evt = link_evt.rx_frame_stb & rx_pend_q & ~data_rd;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_buf_q <= 16'h0000;
			rx_buf_q <= 16'h0000;
			tx_empty_q <= `SAP_STAT_RST == 16'h0002;
			rx_pend_q <= 1'b0;
			ch_side_q <= 1'b0;
			transfer_active_q <= 1'b0;
		end else begin
			transfer_active_q <= link_evt.transfer_active;
			if (data_wr) begin
				tx_buf_q <= merge16(tx_buf_q, apb_req.pwdata, apb_req.pstrb) & fmask;
				tx_empty_q <= 1'b0;
			end else if (link_evt.tx_take) begin
				tx_empty_q <= 1'b1;
			end
			if (rx_acc) begin
				rx_buf_q <= link_evt.rx_word & fmask;
				rx_pend_q <= 1'b1;
			end else if (data_rd) begin
				rx_pend_q <= 1'b0;
			end
			if (link_evt.tx_take | rx_acc) begin
				ch_side_q <= link_evt.channel_side;
			end
		end
	end

	// Error flags; a set in the same cycle as a clear wins
	assign sel_low = pcfg_q.soft_select_enable ? ~pcfg_q.soft_select_level : ~ss_sync_q;
	assign fault_evt = pcfg_q.master_mode & ~audio_sel & sel_low;
	assign mismatch_evt = link_evt.rx_sum_stb & pcfg_q.checksum_enable & ~audio_sel
		& ((link_evt.rx_word & fmask) != rx_sum_q);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_ovr_q <= 1'b0;
			ovr_arm_q <= 1'b0;
		end else begin
			if (ovr_evt) begin
				rx_ovr_q <= 1'b1;
			end else if (stat_rd & ovr_arm_q) begin
				rx_ovr_q <= 1'b0;
			end
			if (data_rd) begin
				ovr_arm_q <= 1'b1;
			end else if (stat_rd) begin
				ovr_arm_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_fault_q <= 1'b0;
			cfg_arm_q <= 1'b0;
		end else begin
			if (fault_evt) begin
				cfg_fault_q <= 1'b1;
			end else if (ctl_wr & cfg_arm_q) begin
				cfg_fault_q <= 1'b0;
			end
			if (stat_rd | stat_wr) begin
				cfg_arm_q <= 1'b1;
			end else if (ctl_wr) begin
				cfg_arm_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mismatch_q <= 1'b0;
			tx_ur_q <= 1'b0;
		end else begin
			if (mismatch_evt) begin
				mismatch_q <= 1'b1;
			end else if (stat_wr & apb_req.pstrb[0] & ~apb_req.pwdata[`SAP_STAT_MISMATCH]) begin
				mismatch_q <= 1'b0;
			end
			if (link_evt.underrun_evt & audio_sel) begin
				tx_ur_q <= 1'b1;
			end else if (stat_rd) begin
				tx_ur_q <= 1'b0;
			end
		end
	end

	// Checksum generators, bits arrive in wire order so bit order shapes the value
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_sum_q <= 16'h0000;
			tx_sum_q <= 16'h0000;
		end else if (sum_clr) begin
			rx_sum_q <= 16'h0000;
			tx_sum_q <= 16'h0000;
		end else if (pcfg_q.checksum_enable & ~audio_sel) begin
			if (link_evt.rx_bit_stb) begin
				rx_sum_q <= sum_step(rx_sum_q, poly_q, link_evt.rx_bit, pcfg_q.frame16);
			end
			if (link_evt.tx_bit_stb) begin
				tx_sum_q <= sum_step(tx_sum_q, poly_q, link_evt.tx_bit, pcfg_q.frame16);
			end
		end
	end

	// Audio clocks: divider enable pulse, master clock and idle-aware bit clock
	assign divisor = ({apsc_q[7:0], 1'b0} + {8'h00, apsc_q[`SAP_APSC_ODD]}) < `SAP_DIV_MIN
		? `SAP_DIV_MIN : {apsc_q[7:0], 1'b0} + {8'h00, apsc_q[`SAP_APSC_ODD]};
	assign running = actl_q[11] & actl_q[10] & actl_q[9];
	assign tick = div_cnt_q == divisor - 9'h001;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div_cnt_q <= 9'h000;
			mck_q <= 1'b0;
			bck_q <= 1'b0;
			audio_cfg_q <= sap_audio_cfg_t'(11'h000);
		end else begin
			audio_cfg_q <= sap_audio_cfg_t'({actl_q[11:7], actl_q[5:0]});
			if (!running | tick) begin
				div_cnt_q <= 9'h000;
			end else begin
				div_cnt_q <= div_cnt_q + 9'h001;
			end
			mck_q <= running & apsc_q[`SAP_APSC_MASTER_CLOCK_OUT_ENABLE] & (div_cnt_q < (divisor >> 1));
			if (!running) begin
				bck_q <= actl_q[3];
			end else if (tick) begin
				bck_q <= ~bck_q;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign tx_buffer = tx_buf_q;
	assign tx_buffer_empty = tx_empty_q;
	assign tx_checksum = tx_sum_q;
	assign port_cfg = pcfg_q;
	assign audio_cfg = audio_cfg_q;
	assign audio_bit_clock = bck_q;
	assign audio_master_clock = mck_q;

endmodule : sap_regs

// [sap_link_model.sv]
/* Link-side shifter model that pulses bit, frame and checksum events.
   Assumes the bench calls its tasks just after a rising sys_clk edge. */
`timescale 1ns/100ps
module sap_link_model
	import sap_pkg::*;
(
	input wire logic sys_clk,
	output sap_link_evt_t ev
);
	initial ev = '0;

	// One cycle of events, then idle with the word lines inverted
	task automatic pulse(input sap_link_evt_t e);
		sap_link_evt_t z;
		z = '0;
		z.rx_word = ~e.rx_word;
		@(posedge sys_clk);
		ev <= e;
		@(posedge sys_clk);
		ev <= z;
	endtask : pulse

	// Shift n bits of a word in wire order
	task automatic shift(input logic tx, input logic [15:0] w, input int n, input logic lsbf);
		sap_link_evt_t e;
		for (int i = 0; i < n; i++) begin
			e = '0;
			e.transfer_active = 1'b1;
			e.tx_bit_stb = tx;
			e.rx_bit_stb = !tx;
			e.tx_bit = lsbf ? w[i] : w[n - 1 - i];
			e.rx_bit = e.tx_bit;
			pulse(e);
		end
	endtask : shift
endmodule : sap_link_model

// [sap_regs_asserts.sv]
/* Port-level checks of the serial audio port registers.
   Assumes binding into sap_regs on one clock with synchronous reset. */
`timescale 1ns/100ps
module sap_regs_asserts
	import sap_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire sap_apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire sap_link_evt_t link_evt,
	input wire logic peripheral_reset_bit,
	input wire logic [15:0] tx_buffer,
	input wire logic tx_buffer_empty,
	input wire logic [15:0] tx_checksum,
	input wire sap_port_cfg_t port_cfg,
	input wire sap_audio_cfg_t audio_cfg,
	input wire logic audio_bit_clock,
	input wire logic audio_master_clock
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic setup, acc, wr_data, cfg_wr, run, mapped;
	logic [15:0] wexp_q;
	assign setup = apb_req.psel && !apb_req.penable;
	assign acc = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
	assign wr_data = acc && apb_req.paddr == 8'h0C && apb_req.pstrb == 4'hF;
	assign cfg_wr = acc && apb_req.paddr == 8'h24;
	assign run = audio_cfg.audio_mode_select && audio_cfg.audio_enable
		&& audio_cfg.audio_op_mode[1];
	assign mapped = apb_req.paddr inside {8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};

	// Expected buffer content of a data write
	always_ff @(posedge sys_clk) begin
		wexp_q <= port_cfg.frame16 ? apb_req.pwdata[15:0] : {8'h00, apb_req.pwdata[7:0]};
	end

	a_ready_once: assert property (setup |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");
	a_slverr_map: assert property (setup |=> pslverr == !mapped)
		else $error("pslverr disagrees with map");
	a_unmapped_zero: assert property (setup && !apb_req.pwrite && !mapped |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_write_full: assert property (wr_data |=> !tx_buffer_empty && tx_buffer == wexp_q)
		else $error("data write not held in buffer");
	a_take_empty: assert property (link_evt.tx_take && !(acc && apb_req.paddr == 8'h0C)
		|=> tx_buffer_empty) else $error("buffer not empty after take");
	a_prst_clear: assert property (peripheral_reset_bit |=> tx_checksum == 16'h0000)
		else $error("checksum not cleared");
	a_tsum_hold: assert property (!link_evt.tx_bit_stb && !peripheral_reset_bit && !cfg_wr
		|=> $stable(tx_checksum)) else $error("checksum moved without a bit");
	a_idle_clk: assert property (!run ##1 (!run && $stable(audio_cfg))
		|-> audio_bit_clock == audio_cfg.idle_clock_level) else $error("bad idle clock level");
	a_mclk_off: assert property (!run ##1 !run |-> !audio_master_clock)
		else $error("master clock while stopped");
endmodule : sap_regs_asserts

bind sap_regs sap_regs_asserts u_chk (.sys_clk(sys_clk), .srst(srst), .apb_req(apb_req),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_evt(link_evt),
	.peripheral_reset_bit(peripheral_reset_bit), .tx_buffer(tx_buffer),
	.tx_buffer_empty(tx_buffer_empty), .tx_checksum(tx_checksum), .port_cfg(port_cfg),
	.audio_cfg(audio_cfg), .audio_bit_clock(audio_bit_clock),
	.audio_master_clock(audio_master_clock));

// [testbench.sv]
/* Self-checking bench of the serial audio port registers.
   Assumes sap_regs, the link model and the bound checker. */
`timescale 1ns/100ps
module testbench;
	import sap_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic slave_select = 1'b1;
	logic prst = 1'b0;
	logic err;
	sap_apb_req_t req = '0;
	sap_link_evt_t ev;
	logic [31:0] prdata;
	logic pready, pslverr, tx_buffer_empty, bclk, mclk;
	logic [15:0] tx_buffer, tx_checksum;
	sap_port_cfg_t port_cfg;
	sap_audio_cfg_t audio_cfg;
	logic [31:0] rv [8] = '{32'h2, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0};
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #10 sys_clk = ~sys_clk;

	sap_regs DUT (.sys_clk(sys_clk), .srst(srst), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_evt(ev), .slave_select(slave_select),
		.peripheral_reset_bit(prst), .tx_buffer(tx_buffer), .tx_buffer_empty(tx_buffer_empty),
		.tx_checksum(tx_checksum), .port_cfg(port_cfg), .audio_cfg(audio_cfg),
		.audio_bit_clock(bclk), .audio_master_clock(mclk));
	sap_link_model u_link (.sys_clk(sys_clk), .ev(ev));

	task automatic test_done;
		$display("Compares %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge sys_clk);
		req <= '{1'b1, 1'b0, w, a, d, 4'hF};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		req <= '0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		apb(1'b0, a, 32'h0, r);
	endtask : rd

	function automatic logic [15:0] crc(input logic [15:0] p, input logic [15:0] w,
		input int n, input logic lsbf);
		logic [15:0] c;
		logic b;
		c = 16'h0000;
		for (int i = 0; i < n; i++) begin
			b = lsbf ? w[i] : w[n - 1 - i];
			c = {c[14:0], 1'b0} ^ ((b ^ (n == 8 ? c[7] : c[15])) ? p : 16'h0000);
		end
		return n == 8 ? {8'h00, c[7:0]} : c;
	endfunction : crc

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 6000) begin
			mismatches++;
			test_done();
		end
	end

	// Rise-to-rise period of the bit clock (sel 0) or the master clock (sel 1)
	task automatic edge_gap(input logic sel, output int n);
		n = 0;
		do @(posedge sys_clk); while ((sel ? mclk : bclk) !== 1'b0);
		do @(posedge sys_clk); while ((sel ? mclk : bclk) !== 1'b1);
		do begin
			@(posedge sys_clk);
			n++;
		end while ((sel ? mclk : bclk) !== 1'b0);
		do begin
			@(posedge sys_clk);
			n++;
		end while ((sel ? mclk : bclk) !== 1'b1);
	endtask : edge_gap

	initial begin
		logic [31:0] r;
		logic [31:0] v;
		logic [15:0] w;
		logic [15:0] p;
		logic [15:0] c;
		logic [7:0] dv;
		logic odd;
		int n;
		v = $urandom(32'h478F);
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(8'h08 + 8'(4 * i), r);
			chk(r, rv[i]);
		end
		rd(8'h28, r);
		chk({r[30:0], err}, 32'h1);
		wr(8'h18, $urandom);
		rd(8'h18, r);
		chk(r, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = ($urandom & 32'hFFFF_F0CF) | (i << 8) | (i << 4);
			wr(8'h1C, v);
			rd(8'h1C, r);
			chk(r, v & 32'h0FBF);
			chk(32'(audio_cfg), {21'h0, v[11:7], v[5:0]});
		end
		v = $urandom | 32'h1;
		wr(8'h20, v);
		rd(8'h20, r);
		chk(r, v & 32'h3FF);
		wr(8'h1C, 32'h0);
		for (int k = 0; k < 2; k++) begin
			w = 16'($urandom);
			wr(8'h24, 32'(k * 2));
			wr(8'h0C, {16'hFFFF, w});
			@(posedge sys_clk);
			chk(tx_buffer, k ? w : {8'h00, w[7:0]});
		end
		rd(8'h08, r);
		chk(r[1], 1'b0);
		u_link.pulse('{tx_take: 1'b1, channel_side: 1'b1, default: '0});
		rd(8'h08, r);
		chk(r[2:1], 2'b11);
		wr(8'h1C, 32'h800);
		u_link.pulse('{underrun_evt: 1'b1, default: '0});
		rd(8'h08, r);
		chk(r[3], 1'b1);
		rd(8'h08, r);
		chk(r[3], 1'b0);
		wr(8'h1C, 32'h0);
		u_link.pulse('{rx_frame_stb: 1'b1, rx_word: w, default: '0});
		rd(8'h08, r);
		chk({r[6], r[0]}, 2'b01);
		u_link.pulse('{rx_frame_stb: 1'b1, rx_word: ~w, default: '0});
		rd(8'h08, r);
		rd(8'h08, r);
		chk({r[6], r[0]}, 2'b11);
		rd(8'h0C, r);
		chk(r, {16'h0, w});
		rd(8'h08, r);
		chk({r[6], r[0]}, 2'b10);
		rd(8'h08, r);
		chk(r[6], 1'b0);
		for (int k = 0; k < 2; k++) begin
			p = 16'($urandom);
			w = 16'($urandom);
			c = crc(p, w, 8 + 8 * k, k[0]);
			wr(8'h10, {16'h0, p});
			wr(8'h24, 32'(k * 2));
			wr(8'h24, 32'(k * 18 + 1));
			u_link.shift(1'b1, w, 8 + 8 * k, k[0]);
			@(posedge sys_clk);
			chk(tx_checksum, c);
			u_link.shift(1'b0, w, 8 + 8 * k, k[0]);
			rd(8'h14, r);
			chk(r, c);
			u_link.pulse('{rx_sum_stb: 1'b1, rx_word: c, default: '0});
			rd(8'h08, r);
			chk(r[4], 1'b0);
			u_link.pulse('{rx_sum_stb: 1'b1, rx_word: c ^ 16'h0001, default: '0});
			rd(8'h08, r);
			chk(r[4], 1'b1);
			wr(8'h08, 32'h0);
			rd(8'h08, r);
			chk(r[4], 1'b0);
		end
		@(posedge sys_clk);
		prst <= 1'b1;
		@(posedge sys_clk);
		prst <= 1'b0;
		rd(8'h14, r);
		chk({r[15:0], tx_checksum}, 32'h0);
		dv = 8'(1 + $urandom % 20);
		odd = 1'($urandom);
		wr(8'h20, {22'h0, 1'b1, odd, dv});
		wr(8'h1C, 32'hB08);
		repeat (2) @(posedge sys_clk);
		chk({bclk, mclk}, 2'b10);
		wr(8'h1C, 32'hF08);
		edge_gap(1'b0, n);
		chk(n, 4 * dv + 2 * odd);
		edge_gap(1'b1, n);
		chk(n, 2 * dv + odd);
		wr(8'h1C, 32'hB08);
		repeat (2) @(posedge sys_clk);
		chk({bclk, mclk}, 2'b10);
		wr(8'h1C, 32'h0);
		wr(8'h24, 32'h60);
		slave_select <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(8'h08, r);
		chk(r[5], 1'b1);
		slave_select <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(8'h08, r);
		wr(8'h24, 32'h6C);
		rd(8'h08, r);
		chk(r[5], 1'b0);
		wr(8'h24, 32'h64);
		rd(8'h08, r);
		chk(r[5], 1'b1);
		test_done();
	end
endmodule : testbench
